// File: psos_pkg.sv
// Purpose: shared constants for the parallel-in serial-out shifter
// Assumes: one 125 MHz clock, inputs synchronous to it
// Notes: stage 0 is the first stage, the top stage is the last
package psos_pkg;
    localparam int PSOS_STAGES = 8;          // register length
    localparam int PSOS_CLK_PERIOD_NS = 8;   // system clock period
    localparam int PSOS_BUF_DEPTH = 2;       // entries in the bit buffer
    localparam int PSOS_BUF_WIDTH = 1;       // one shifted-out bit per entry
    localparam logic PSOS_LOAD_IDLE = 1'b1;  // shift/load level at rest
    localparam logic PSOS_NOR_IDLE = 1'b1;   // assumed gate level before reset release
endpackage : psos_pkg

// File: psos_buf.sv
// Purpose: small ring buffer with valid/ready on both sides
// Assumes: depth of at least two, single clock
// Notes: read data, valid and ready all come from flip-flops
`timescale 1ns/1ps
module psos_buf #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready_ff,
    output logic out_valid_ff,
    output logic [WIDTH-1:0] out_data_ff,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic [PW-1:0] nxt_rd_ptr;
    logic [CW-1:0] nxt_count;
    logic push;
    logic pop;

    // a push into a full buffer is refused, never overwrites
    assign push = in_valid && in_ready_ff;
    assign pop = out_valid_ff && out_ready;

    // pointer and level bookkeeping
    always_comb begin
        nxt_rd_ptr = rd_ptr_ff;
        if (pop) begin
            nxt_rd_ptr = (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
        end
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_count = count_ff - 1'b1;
        end
    end

    // storage array, no reset needed on data
    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // pointers, level and flag flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            in_ready_ff <= 1'b0;
            out_valid_ff <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
            end
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            in_ready_ff <= (nxt_count != FULL_CNT);
            out_valid_ff <= (nxt_count != '0);
        end
    end

    // head word registered; bypass when the write lands on the new head
    always_ff @(posedge clock) begin
        if (push && (wr_ptr_ff == nxt_rd_ptr)) begin
            out_data_ff <= in_data;
        end else begin
            out_data_ff <= mem_ff[nxt_rd_ptr];
        end
    end
endmodule : psos_buf

// File: psos_shifter.sv
// Purpose: eight-stage parallel-in, serial-out shift register
// Assumes: all pins but rst_b sampled synchronously to clock; edges seen as level changes
// Notes: shift register itself carries no reset
// Operation
// RULE1: eight stages shift first toward last
// RULE2: load low copies parallel inputs into stages
// RULE3: load wins over clock, inhibit, serial
// RULE4: parallel inputs ignored while load high
// RULE5: shift clock is NOR of both clocks
// RULE6: rising gated clock with load high shifts once; here only if the bit buffer has room
// RULE7: first stage takes serial, others previous
// RULE8: no gated rising edge means hold
// RULE9: last stage out true and inverted only
// RULE10: controller raises inhibit only while clock high
// RULE11: no reset; contents unknown until loaded
`timescale 1ns/1ps
module psos_shifter
    import psos_pkg::*;
#(
    parameter int STAGES = psos_pkg::PSOS_STAGES,
    parameter int BUF_DEPTH = psos_pkg::PSOS_BUF_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic shift_load_b,
    input wire logic clk_in,
    input wire logic clk_inhibit,
    input wire logic serial_in,
    input wire logic [STAGES-1:0] par_in,
    output logic last_q_ff,
    output logic last_q_b_ff,
    output logic step_ready_ff,
    output logic bit_valid_ff,
    output logic bit_data_ff,
    input wire logic bit_ready
);
    import psos_pkg::*;

    // phase of the nor-gated clock; the two codes sit one bit apart
    typedef enum logic {
        GATE_SHUT = 1'b0, // gate low, the next rise steps if load is high and the buffer has room
        GATE_OPEN = 1'b1 // gate high, its rise already spent
    } psos_gate_e;

    // stage register, no reset by design
    logic [STAGES-1:0] stage_ff;
    wire logic [STAGES-1:0] nxt_stage;
    // pin history
    logic load_prev_ff;
    psos_gate_e gate_state_ff;
    psos_gate_e nxt_gate_state;
    // decoded pin conditions
    logic gate_now;
    logic gate_rise;
    logic load_fall;
    logic load_now;
    logic step;
    // last stage on its way to the output flops
    logic nxt_last_q;
    logic nxt_last_q_b;
    // buffer side
    logic buf_ready_ff;
    logic buf_push;
    logic buf_bit;

    // the two clock pins meet in a nor; high on either blocks shifting
    assign gate_now = ~(clk_in | clk_inhibit); // [RULE5]

    // a rise counts only if the gate was seen low at the last edge
    assign gate_rise = gate_now && (gate_state_ff == GATE_SHUT);

    // gate phase tracking; an unknown code falls back to open, never a step
    always_comb begin
        nxt_gate_state = gate_state_ff;
        case (gate_state_ff)
            GATE_SHUT: begin
                if (gate_now) begin
                    nxt_gate_state = GATE_OPEN;
                end
            end
            GATE_OPEN: begin
                if (!gate_now) begin
                    nxt_gate_state = GATE_SHUT;
                end
            end
            default: begin
                nxt_gate_state = GATE_OPEN;
            end
        endcase
    end

    // gate phase flop; reset to the idle level so release fakes no rise
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gate_state_ff <= psos_gate_e'(PSOS_NOR_IDLE);
        end else begin
            gate_state_ff <= nxt_gate_state;
        end
    end

    // load pin history; reset to its rest level so release fakes no fall
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            load_prev_ff <= PSOS_LOAD_IDLE;
        end else begin
            load_prev_ff <= shift_load_b;
        end
    end

    // load acts on its level, its falling edge being the first such cycle
    assign load_fall = !shift_load_b && load_prev_ff;
    assign load_now = !shift_load_b || load_fall; // [RULE3]

    // a step needs load high and buffer room, so no shifted bit is lost;
    // a rise that meets a full buffer is spent without a shift
    assign step = !load_now && gate_rise && buf_ready_ff; // [RULE6]

    // per-stage next value: load first, then a step, otherwise hold
    for (genvar g = 0; g < STAGES; g++) begin : g_stage
        logic shift_src;
        // the first stage listens to the serial pin, the rest to the one below
        if (g == 0) begin : g_first
            assign shift_src = serial_in; // [RULE7]
        end else begin : g_rest
            assign shift_src = stage_ff[g-1]; // [RULE1]
        end
        // par_in reaches a stage only through the load term [RULE4]
        assign nxt_stage[g] = load_now ? par_in[g] // [RULE2]
            : (step ? shift_src : stage_ff[g]); // [RULE8]
    end

    // the stages have no reset, power-up content is unknown [RULE11]
    always_ff @(posedge clock) begin
        stage_ff <= nxt_stage;
    end

    // only the last stage is brought out, true and inverted
    assign nxt_last_q = nxt_stage[STAGES-1];
    assign nxt_last_q_b = ~nxt_stage[STAGES-1];

    // true copy, taken from the next value so it matches the stage
    always_ff @(posedge clock) begin
        last_q_ff <= nxt_last_q; // [RULE9]
    end

    // inverted copy in a flop of its own so both pins switch on one edge
    always_ff @(posedge clock) begin
        last_q_b_ff <= nxt_last_q_b; // [RULE9]
    end

    // ready mirror lags the buffer by one edge; a controller that steps
    // on it can still meet a full buffer right after a push
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            step_ready_ff <= 1'b0;
        end else begin
            step_ready_ff <= buf_ready_ff;
        end
    end

    // each step pushes the bit leaving the last stage
    assign buf_push = step;
    assign buf_bit = stage_ff[STAGES-1];

    // two-entry buffer so a stalled sink loses no shifted bit
    psos_buf #(
        .WIDTH(PSOS_BUF_WIDTH),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clock(clock),
        .rst_b(rst_b),
        .in_valid(buf_push),
        .in_data(buf_bit),
        .in_ready_ff(buf_ready_ff),
        .out_valid_ff(bit_valid_ff),
        .out_data_ff(bit_data_ff),
        .out_ready(bit_ready)
    );
endmodule : psos_shifter

// File: psos_sink.sv
// Purpose: sink model for shifted-out bits
// Assumes: bench requests stalls through hold_off
// Notes: ready moves only just after an edge
`timescale 1ns/1ps
module psos_sink (
    input wire logic clock,
    input wire logic hold_off,
    input wire logic bit_valid_ff,
    input wire logic bit_data_ff,
    output logic bit_ready
);
    logic got[$];
    initial bit_ready = 1'b0;
    // take the head on a handshake edge; a stall only lowers ready
    always @(posedge clock) begin
        if (bit_valid_ff && bit_ready) begin
            got.push_back(bit_data_ff);
        end
        bit_ready <= !hold_off;
    end
endmodule : psos_sink

// File: psos_asserts.sv
// Purpose: port checks for the shifter
// Assumes: pins change just after clock edges
// Notes: stages have no reset, so seen_ff masks them until a load
`timescale 1ns/1ps
module psos_asserts #(
    parameter int STAGES = 8
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic shift_load_b,
    input wire logic clk_in,
    input wire logic clk_inhibit,
    input wire logic [STAGES-1:0] par_in,
    input wire logic last_q_ff,
    input wire logic last_q_b_ff,
    input wire logic step_ready_ff,
    input wire logic bit_valid_ff,
    input wire logic bit_data_ff,
    input wire logic bit_ready
);
    logic seen_ff = 1'b0;
    logic gate;
    assign gate = !(clk_in || clk_inhibit);
    // first load makes stage contents known; kept across rst_b like the stages
    always @(posedge clock) begin
        if (!shift_load_b) begin
            seen_ff <= 1'b1;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    a_load_true: assert property (!shift_load_b |=> last_q_ff == $past(par_in[STAGES-1]))
        else $error("load value");
    a_load_inv: assert property (!shift_load_b |=> last_q_b_ff == !$past(par_in[STAGES-1]))
        else $error("load inverse");
    a_hold_gated: assert property (seen_ff && shift_load_b && !gate |=> $stable(last_q_ff))
        else $error("gated hold");
    a_no_rise: assert property (seen_ff && shift_load_b && gate && $past(gate) |=> $stable(last_q_ff))
        else $error("step without rise");
    a_step_push: assert property (seen_ff && shift_load_b && gate && !$past(gate) && step_ready_ff
        && !bit_valid_ff |=> bit_valid_ff && bit_data_ff == $past(last_q_ff))
        else $error("step bit");
    a_out_pair: assert property (seen_ff |-> last_q_b_ff != last_q_ff)
        else $error("outputs not complementary");
    a_bit_stands: assert property (bit_valid_ff && !bit_ready |=> bit_valid_ff && $stable(bit_data_ff))
        else $error("head bit moved");
    a_load_no_push: assert property (!shift_load_b && !$past(shift_load_b) && !bit_valid_ff
        |=> !bit_valid_ff)
        else $error("load pushed a bit");
endmodule : psos_asserts
bind psos_shifter psos_asserts #(.STAGES(STAGES)) u_chk (.clock(clock), .rst_b(rst_b),
    .shift_load_b(shift_load_b), .clk_in(clk_in), .clk_inhibit(clk_inhibit), .par_in(par_in),
    .last_q_ff(last_q_ff), .last_q_b_ff(last_q_b_ff), .step_ready_ff(step_ready_ff),
    .bit_valid_ff(bit_valid_ff), .bit_data_ff(bit_data_ff), .bit_ready(bit_ready));

// File: tb_top.sv
// Purpose: bench for the shifter
// Assumes: sink model pops the bit stream
// Notes: pins driven by NBA at rising edges
`timescale 1ns/1ps
module tb_top;
    import psos_pkg::*;
    logic clock = 0, rst_b = 0, shift_load_b = 1, clk_in = 1, clk_inhibit = 0, serial_in = 0;
    logic hold_off = 0, bit_ready, last_q_ff, last_q_b_ff, step_ready_ff, bit_valid_ff, bit_data_ff;
    logic [PSOS_STAGES-1:0] par_in = 8'h00;
    int bad_count = 0, comparisons = 0;
    initial forever #4 clock = ~clock;
    psos_shifter u_dut (.clock(clock), .rst_b(rst_b), .shift_load_b(shift_load_b), .clk_in(clk_in),
        .clk_inhibit(clk_inhibit), .serial_in(serial_in), .par_in(par_in), .last_q_ff(last_q_ff),
        .last_q_b_ff(last_q_b_ff), .step_ready_ff(step_ready_ff), .bit_valid_ff(bit_valid_ff),
        .bit_data_ff(bit_data_ff), .bit_ready(bit_ready));
    psos_sink u_sink (.clock(clock), .hold_off(hold_off), .bit_valid_ff(bit_valid_ff),
        .bit_data_ff(bit_data_ff), .bit_ready(bit_ready));
    task automatic finish_test();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic check(logic seen, logic exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %0t value mismatch", $time);
        end
    endtask : check
    task automatic tick(int n);
        repeat (n) @(posedge clock);
    endtask : tick
    // clock low with load low: the gate rise must lose to the load
    task automatic load(logic [7:0] p);
        shift_load_b <= 0; par_in <= p; clk_in <= 0;
        tick(1);
        shift_load_b <= 1; clk_in <= 1; par_in <= ~p; // changed inputs must be ignored
        tick(2);
        check(last_q_ff, p[7]);
        check(last_q_b_ff, !p[7]);
    endtask : load
    task automatic pulse(logic s);
        clk_in <= 0; serial_in <= s;
        tick(2);
        clk_in <= 1;
        tick(1);
    endtask : pulse
    task automatic step(logic s);
        for (int i = 0; i < 40 && step_ready_ff !== 1'b1; i++) tick(1);
        if (step_ready_ff !== 1'b1) begin
            bad_count++;
            finish_test();
        end else begin
            pulse(s);
        end
    endtask : step
    task automatic sc_stream(logic [7:0] p, logic [7:0] s);
        int n = u_sink.got.size();
        load(p);
        for (int i = 0; i < 16; i++) step(i < 8 ? s[i] : 1'b0);
        tick(6);
        for (int i = 0; i < 16; i++) check(u_sink.got[n+i], i < 8 ? p[7-i] : s[i-8]);
    endtask : sc_stream
    // inhibit blocks steps; the load edge pushed nothing either
    task automatic sc_hold();
        int n = u_sink.got.size();
        load(8'h80);
        clk_inhibit <= 1; // raised while clk_in is high
        repeat (3) pulse(0);
        clk_inhibit <= 0;
        tick(4);
        check(last_q_ff, 1'b1);
        check(u_sink.got.size() == n, 1'b1);
    endtask : sc_hold
    // full buffer refuses a step rather than dropping a bit
    task automatic sc_stall();
        int n;
        hold_off <= 1;
        load(8'h6c);
        n = u_sink.got.size();
        step(1);
        step(1);
        pulse(1);
        tick(2);
        check(step_ready_ff, 1'b0);
        check(last_q_ff, 1'b1);
        hold_off <= 0;
        tick(8);
        check(u_sink.got.size() == n + 2, 1'b1);
        check(u_sink.got[n], 1'b0);
        check(u_sink.got[n+1], 1'b1);
    endtask : sc_stall
    // mid-run reset empties the bit path but leaves the stages alone
    task automatic sc_reset();
        hold_off <= 1;
        load(8'h80);
        step(0);
        check(last_q_ff, 1'b0);
        check(bit_valid_ff, 1'b1);
        rst_b <= 0;
        tick(2);
        check(last_q_ff, 1'b0);
        check(last_q_b_ff, 1'b1);
        check(bit_valid_ff, 1'b0);
        check(step_ready_ff, 1'b0);
        rst_b <= 1;
        hold_off <= 0;
        tick(3);
        check(step_ready_ff, 1'b1);
        check(last_q_ff, 1'b0);
    endtask : sc_reset
    initial begin
        tick(3);
        rst_b <= 1;
        tick(2);
        sc_stream(8'h5a, 8'hc3);
        sc_hold();
        sc_stall();
        sc_reset();
        sc_stream(8'ha5, 8'h3c);
        finish_test();
    end
endmodule : tb_top
